// file: hdl/tacf_framer.sv
`timescale 1ns/100ps
`default_nettype none
`include "tacf_defs.svh"
module tacf_framer (
  input  wire logic               CLK_I,
  input  wire logic               RST_I,
  input  wire tacf_pkg::tacf_cfg_t CFG_I,
  input  wire logic               CMD_REQA_I,
  input  wire logic               CMD_WUPA_I,
  input  wire logic               CMD_TX_CRC_I,
  input  wire logic               CMD_TX_RAW_I,
  input  wire logic [7:0]         FIFO_DATA_I,
  input  wire logic               FIFO_VALID_I,
  output logic                    FIFO_POP_O,
  output logic                    TX_BIT_O,
  output logic                    TX_EN_O,
  input  wire logic               RX_STB_I,
  input  wire logic               RX_BIT_I,
  input  wire logic               RX_COLL_I,
  input  wire logic               RX_END_I,
  output logic [7:0]              RX_DATA_O,
  output logic                    RX_VALID_O,
  output tacf_pkg::tacf_stat_t    STAT_O
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic odd_par(input logic [7:0] b);
    odd_par = ~^b;
  endfunction

  function automatic logic [7:0] rev8(input logic [7:0] b);
    for (int i = 0; i < 8; i++) rev8[i] = b[7-i];
  endfunction

  // ---------------------------------------------------------------
  // Transmit and timer state
  // ---------------------------------------------------------------
  tacf_pkg::tacf_state_t st, next_st;
  logic [19:0] acc, next_acc;
  logic [1:0]  phase, next_phase;
  logic [8:0]  sh_reg, next_sh_reg;
  logic [3:0]  sh_cnt, next_sh_cnt;
  logic [3:0]  pre_left, next_pre_left;
  logic [8:0]  byte_left, next_byte_left;
  logic [15:0] crc, next_crc;
  logic [7:0]  mask_cnt, next_mask_cnt;
  logic [15:0] nrt_cnt, next_nrt_cnt;
  logic        use_crc, next_use_crc;
  logic        eot, next_eot;
  logic        nre, next_nre;
  logic        len_err, next_len_err;
  logic        tx_bit, next_tx_bit;
  logic        tick, half_step, bit_tick, empty, fm;
  logic [7:0]  crc_byte;
  logic [15:0] crc_step;
  logic [3:0]  pre_bytes;
  logic [8:0]  len_val;
  logic        any_cmd;
  logic [6:0]  short_code, next_short_code;
  // Local aliases of the state names
  localparam tacf_pkg::tacf_state_t
    S_IDLE  = tacf_pkg::S_IDLE,  S_SHORT = tacf_pkg::S_SHORT,
    S_PRE   = tacf_pkg::S_PRE,   S_SYNC0 = tacf_pkg::S_SYNC0,
    S_SYNC1 = tacf_pkg::S_SYNC1, S_LEN   = tacf_pkg::S_LEN,
    S_DATA  = tacf_pkg::S_DATA,  S_CRC0  = tacf_pkg::S_CRC0,
    S_CRC1  = tacf_pkg::S_CRC1,  S_DONE  = tacf_pkg::S_DONE,
    S_MASK  = tacf_pkg::S_MASK,  S_WATCH = tacf_pkg::S_WATCH,
    S_RECV  = tacf_pkg::S_RECV;

  assign fm      = CFG_I.frame_mode;
  assign any_cmd = CMD_REQA_I | CMD_WUPA_I | CMD_TX_CRC_I | CMD_TX_RAW_I;
  assign len_val = CFG_I.tx_count + 9'h001;
  assign empty   = (sh_cnt == 4'h0);

  always_comb begin
    case ({CFG_I.preamble_length_hi, CFG_I.preamble_length_lo})
      2'b00:   pre_bytes = `TACF_PRE_BYTES0;
      2'b01:   pre_bytes = `TACF_PRE_BYTES1;
      2'b10:   pre_bytes = `TACF_PRE_BYTES2;
      default: pre_bytes = `TACF_PRE_BYTES3;
    endcase
  end

  // Fractional divider keeps fc/32 ticks exact on average at 10 MHz
  assign tick      = (acc + `TACF_FC_KHZ) >= `TACF_TICK_LIM;
  assign half_step = tick & phase[0];
  always_comb begin
    if (!fm) begin
      bit_tick = tick & (phase == 2'b11);
    end else if (CFG_I.rate_424) begin
      bit_tick = tick;
    end else begin
      bit_tick = half_step;
    end
  end

  // CRC byte stream: the byte being loaded into the shifter
  assign crc_byte = (st == S_LEN) ? len_val[7:0] : FIFO_DATA_I;

  tacf_crc16 u_tx_crc (
    .crc_i       (crc),
    .data_i      (crc_byte),
    .lsb_first_i (!fm),
    .crc_o       (crc_step)
  );

  always_comb begin
    logic [7:0] ld;
    logic [3:0] nb;
    logic       do_ld;
    ld             = 8'h00;
    nb             = 4'h8;
    do_ld          = 1'b0;
    next_st        = st;
    next_acc       = tick ? acc + `TACF_FC_KHZ - `TACF_TICK_LIM
                          : acc + `TACF_FC_KHZ;
    next_phase     = tick ? phase + 2'b01 : phase;
    next_sh_reg    = sh_reg;
    next_sh_cnt    = sh_cnt;
    next_pre_left  = pre_left;
    next_byte_left = byte_left;
    next_crc       = crc;
    next_mask_cnt  = mask_cnt;
    next_nrt_cnt   = nrt_cnt;
    next_use_crc   = use_crc;
    next_eot       = 1'b0;
    next_nre       = 1'b0;
    next_len_err   = 1'b0;
    next_tx_bit    = tx_bit;
    FIFO_POP_O     = 1'b0;
    if (bit_tick && !empty) begin
      next_tx_bit = sh_reg[0];
      next_sh_reg = {1'b0, sh_reg[8:1]};
      next_sh_cnt = sh_cnt - 4'h1;
    end
    case (st)
      S_IDLE, S_MASK, S_WATCH: begin
        if (st == S_MASK && half_step) begin
          if (mask_cnt <= 8'h01) begin
            next_st = S_WATCH;
          end else begin
            next_mask_cnt = mask_cnt - 8'h01;
          end
        end
        if (st != S_IDLE && half_step && nrt_cnt != 16'h0000) begin
          next_nrt_cnt = nrt_cnt - 16'h0001;
          if (nrt_cnt == 16'h0001) begin
            next_nre = 1'b1;
            next_st  = S_IDLE;
          end
        end
        if (st == S_WATCH && RX_STB_I) begin
          next_st = S_RECV;
        end
        if (any_cmd) begin
          next_crc       = fm ? `TACF_CRCF_INIT : `TACF_CRCA_INIT;
          next_byte_left = CFG_I.tx_count;
          next_pre_left  = pre_pending(pre_bytes);
          next_use_crc   = CMD_TX_CRC_I;
          // Line rests low until the first bit period of the new frame
          next_tx_bit    = 1'b0;
          if (CMD_REQA_I || CMD_WUPA_I) begin
            next_st = S_SHORT;
          end else if (fm && (len_val < `TACF_LEN_MIN
                              || len_val > `TACF_LEN_MAX)) begin
            next_len_err = 1'b1;
            next_st      = S_IDLE;
          end else if (fm) begin
            next_st = S_PRE;
          end else if (CFG_I.tx_count != 9'h000) begin
            next_st = S_DATA;
          end else begin
            next_st = S_IDLE;
          end
        end
      end
      S_SHORT: begin
        if (empty) begin
          ld      = {1'b0, short_code};
          nb      = 4'h7;
          do_ld   = 1'b1;
          next_st = S_DONE;
        end
      end
      S_PRE: begin
        if (empty) begin
          do_ld         = 1'b1;
          next_pre_left = pre_left - 4'h1;
          if (pre_left == 4'h1) next_st = S_SYNC0;
        end
      end
      S_SYNC0: begin
        if (empty) begin
          ld      = `TACF_SYNC_HI;
          do_ld   = 1'b1;
          next_st = S_SYNC1;
        end
      end
      S_SYNC1: begin
        if (empty) begin
          ld      = `TACF_SYNC_LO;
          do_ld   = 1'b1;
          next_st = S_LEN;
        end
      end
      S_LEN: begin
        if (empty) begin
          ld       = len_val[7:0];
          do_ld    = 1'b1;
          next_crc = crc_step;
          next_st  = S_DATA;
        end
      end
      S_DATA: begin
        // An empty FIFO stalls the frame with the last bit held on the line rather than inventing data
        if (empty && FIFO_VALID_I) begin
          ld             = FIFO_DATA_I;
          do_ld          = 1'b1;
          FIFO_POP_O     = 1'b1;
          next_crc       = crc_step;
          next_byte_left = byte_left - 9'h001;
          if (byte_left == 9'h001) begin
            next_st = use_crc ? S_CRC0 : S_DONE;
            if (!fm && !use_crc && CFG_I.tx_last_bits != 3'h0) begin
              nb = {1'b0, CFG_I.tx_last_bits};
            end
          end
        end
      end
      S_CRC0: begin
        if (empty) begin
          ld      = fm ? crc[15:8] : crc[7:0];
          do_ld   = 1'b1;
          next_st = S_CRC1;
        end
      end
      S_CRC1: begin
        if (empty) begin
          ld      = fm ? crc[7:0] : crc[15:8];
          do_ld   = 1'b1;
          next_st = S_DONE;
        end
      end
      S_DONE: begin
        if (empty && bit_tick) begin
          next_eot      = 1'b1;
          next_st       = S_MASK;
          // Without the tolerant bit only the coarse 128/fc grid is used
          next_mask_cnt = CFG_I.antcl ? CFG_I.mask_time
                          : {CFG_I.mask_time[7:1], 1'b0};
          next_nrt_cnt  = CFG_I.nrt_time;
        end
      end
      S_RECV: begin
        if (RX_END_I) next_st = S_IDLE;
      end
      default: next_st = S_IDLE;
    endcase
    if (do_ld) begin
      if (fm) begin
        next_sh_reg = {1'b0, rev8(ld)};
      end else if (nb == 4'h8 && st != S_SHORT) begin
        next_sh_reg = {odd_par(ld), ld};
        nb          = 4'h9;
      end else begin
        next_sh_reg = {1'b0, ld};
      end
      next_sh_cnt = nb;
    end
  end

  // Short-frame code is latched with the command
  assign next_short_code = CMD_WUPA_I ? `TACF_WUPA
                         : (CMD_REQA_I ? `TACF_REQA : short_code);

  function automatic logic [3:0] pre_pending(input logic [3:0] n);
    pre_pending = n;
  endfunction

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      st         <= tacf_pkg::S_IDLE;
      acc        <= 20'h00000;
      phase      <= 2'h0;
      sh_reg     <= 9'h000;
      sh_cnt     <= 4'h0;
      pre_left   <= 4'h0;
      byte_left  <= 9'h000;
      crc        <= 16'h0000;
      mask_cnt   <= 8'h00;
      nrt_cnt    <= 16'h0000;
      use_crc    <= 1'b0;
      eot        <= 1'b0;
      nre        <= 1'b0;
      len_err    <= 1'b0;
      tx_bit     <= 1'b0;
      short_code <= 7'h00;
    end else begin
      st         <= next_st;
      acc        <= next_acc;
      phase      <= next_phase;
      sh_reg     <= next_sh_reg;
      sh_cnt     <= next_sh_cnt;
      pre_left   <= next_pre_left;
      byte_left  <= next_byte_left;
      crc        <= next_crc;
      mask_cnt   <= next_mask_cnt;
      nrt_cnt    <= next_nrt_cnt;
      use_crc    <= next_use_crc;
      eot        <= next_eot;
      nre        <= next_nre;
      len_err    <= next_len_err;
      tx_bit     <= next_tx_bit;
      short_code <= next_short_code;
    end
  end

  // ---------------------------------------------------------------
  // Receive parser (106 kbit/s, 8 data bits plus odd parity)
  // ---------------------------------------------------------------
  logic [7:0]  rx_sh, next_rx_sh;
  logic [3:0]  rx_pos, next_rx_pos;
  logic [7:0]  rx_cnt, next_rx_cnt;
  logic [15:0] rx_crc, next_rx_crc;
  logic        coll_seen, next_coll_seen;
  logic        byte_coll, next_byte_coll;
  logic [7:0]  rx_data, next_rx_data;
  logic        rx_vld, next_rx_vld;
  tacf_pkg::tacf_stat_t rs, next_rs;
  logic [15:0] rx_crc_step;
  logic        rx_act;

  assign rx_act = (st == S_WATCH) || (st == S_RECV);

  tacf_crc16 u_rx_crc (
    .crc_i       (rx_crc),
    .data_i      (rx_sh),
    .lsb_first_i (1'b1),
    .crc_o       (rx_crc_step)
  );

  always_comb begin
    next_rx_sh     = rx_sh;
    next_rx_pos    = rx_pos;
    next_rx_cnt    = rx_cnt;
    next_rx_crc    = rx_crc;
    next_coll_seen = coll_seen;
    next_byte_coll = byte_coll;
    next_rx_data   = rx_data;
    next_rx_vld    = 1'b0;
    next_rs        = rs;
    next_rs.eor       = 1'b0;
    next_rs.frame_err = 1'b0;
    next_rs.par_err   = 1'b0;
    next_rs.crc_err   = 1'b0;
    next_rs.coll      = 1'b0;
    if (!rx_act) begin
      next_rx_pos    = 4'h0;
      next_rx_cnt    = 8'h00;
      next_rx_crc    = `TACF_CRCA_INIT;
      next_coll_seen = 1'b0;
      next_byte_coll = 1'b0;
    end else if (RX_STB_I && !RX_END_I) begin
      if (rx_pos != 4'h8) begin
        next_rx_sh  = {RX_BIT_I, rx_sh[7:1]};
        next_rx_pos = rx_pos + 4'h1;
        if (RX_COLL_I) begin
          next_byte_coll = 1'b1;
          if (!coll_seen) begin
            // Position 0 marks a collision right on a byte boundary
            next_coll_seen    = 1'b1;
            next_rs.coll      = 1'b1;
            next_rs.coll_byte = rx_cnt;
            next_rs.coll_bit  = rx_pos[2:0];
          end
          next_rs.frame_err = !CFG_I.antcl;
        end
      end else begin
        // A collided byte carries no trustworthy parity
        next_rs.par_err = (RX_BIT_I != odd_par(rx_sh))
                          && !(CFG_I.antcl && byte_coll);
        next_rx_data   = rx_sh;
        next_rx_vld    = 1'b1;
        next_rx_cnt    = rx_cnt + 8'h01;
        next_rx_crc    = rx_crc_step;
        next_rx_pos    = 4'h0;
        next_byte_coll = 1'b0;
      end
    end else if (RX_END_I && st == S_RECV) begin
      next_rs.eor       = 1'b1;
      next_rs.last_bits = 3'h0;
      if (rx_pos != 4'h0 && rx_pos != 4'h8) begin
        if (CFG_I.antcl) begin
          // Align the tail bits down; no parity follows them
          next_rx_data      = rx_sh >> (4'h8 - rx_pos);
          next_rx_vld       = 1'b1;
          next_rs.last_bits = rx_pos[2:0];
        end else begin
          next_rs.frame_err = 1'b1;
        end
      end
      next_rs.crc_err = !CFG_I.no_crc_rx && rx_crc != 16'h0000;
    end
    next_rs.eot     = eot;
    next_rs.nre     = nre;
    next_rs.len_err = len_err;
    next_rs.rx_on   = (next_st == S_WATCH) || (next_st == S_RECV);
    next_rs.busy    = next_st != S_IDLE;
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      rx_sh     <= 8'h00;
      rx_pos    <= 4'h0;
      rx_cnt    <= 8'h00;
      rx_crc    <= 16'h0000;
      coll_seen <= 1'b0;
      byte_coll <= 1'b0;
      rx_data   <= 8'h00;
      rx_vld    <= 1'b0;
      rs        <= '0;
    end else begin
      rx_sh     <= next_rx_sh;
      rx_pos    <= next_rx_pos;
      rx_cnt    <= next_rx_cnt;
      rx_crc    <= next_rx_crc;
      coll_seen <= next_coll_seen;
      byte_coll <= next_byte_coll;
      rx_data   <= next_rx_data;
      rx_vld    <= next_rx_vld;
      rs        <= next_rs;
    end
  end

  assign TX_BIT_O   = tx_bit;
  assign TX_EN_O    = rs.busy && !rs.rx_on;
  assign RX_DATA_O  = rx_data;
  assign RX_VALID_O = rx_vld;
  assign STAT_O     = rs;
endmodule
`default_nettype wire

// file: pkg/tacf_defs.svh
`ifndef TACF_DEFS_SVH
`define TACF_DEFS_SVH
// ---------------------------------------------------------------
// Carrier and clock, in kHz; ticks are generated at fc/32
// ---------------------------------------------------------------
`define TACF_FC_KHZ     20'h034f8
`define TACF_CLK_KHZ    20'h02710
`define TACF_TICK_FC    20'h00020
`define TACF_TICK_LIM   (`TACF_CLK_KHZ * `TACF_TICK_FC)
// ---------------------------------------------------------------
// Frame constants
// ---------------------------------------------------------------
`define TACF_REQA       7'h26
`define TACF_WUPA       7'h52
`define TACF_SYNC_HI    8'hb2
`define TACF_SYNC_LO    8'h4d
`define TACF_PRE_BYTES0 4'h6
`define TACF_PRE_BYTES1 4'h8
`define TACF_PRE_BYTES2 4'ha
`define TACF_PRE_BYTES3 4'hc
`define TACF_LEN_MIN    9'h002
`define TACF_LEN_MAX    9'h0ff
`define TACF_CRCA_INIT  16'h6363
`define TACF_CRCF_INIT  16'h0000
`define TACF_POLY_MSB   16'h1021
`define TACF_POLY_LSB   16'h8408
`endif

// file: pkg/tacf_pkg.sv
package tacf_pkg;
  typedef enum {
    S_IDLE, S_SHORT, S_PRE, S_SYNC0, S_SYNC1, S_LEN, S_DATA,
    S_CRC0, S_CRC1, S_DONE, S_MASK, S_WATCH, S_RECV
  } tacf_state_t;

  typedef struct packed {
    logic       antcl;
    logic       no_crc_rx;
    logic       frame_mode;
    logic       rate_424;
    logic       preamble_length_hi;
    logic       preamble_length_lo;
    logic [7:0] mask_time;
    logic [15:0] nrt_time;
    logic [8:0] tx_count;
    logic [2:0] tx_last_bits;
  } tacf_cfg_t;

  typedef struct packed {
    logic       eot;
    logic       eor;
    logic       nre;
    logic       len_err;
    logic       frame_err;
    logic       par_err;
    logic       crc_err;
    logic       coll;
    logic [7:0] coll_byte;
    logic [2:0] coll_bit;
    logic [2:0] last_bits;
    logic       rx_on;
    logic       busy;
  } tacf_stat_t;
endpackage

// file: hdl/tacf_crc16.sv
`timescale 1ns/100ps
`default_nettype none
`include "tacf_defs.svh"
// ---------------------------------------------------------------
// One-byte step of CRC-16, either bit order
// ---------------------------------------------------------------
module tacf_crc16 (
  input  wire logic [15:0] crc_i,
  input  wire logic [7:0]  data_i,
  input  wire logic        lsb_first_i,
  output logic      [15:0] crc_o
);
  always_comb begin
    logic [15:0] c;
    c = crc_i;
    for (int i = 0; i < 8; i++) begin
      if (lsb_first_i) begin
        c = (c[0] ^ data_i[i]) ? ((c >> 1) ^ `TACF_POLY_LSB) : (c >> 1);
      end else begin
        c = (c[15] ^ data_i[7-i]) ? ((c << 1) ^ `TACF_POLY_MSB)
                                  : (c << 1);
      end
    end
    crc_o = c;
  end
endmodule
`default_nettype wire

// file: dv/tacf_framer_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module tacf_framer_chk (
  input  wire logic                 CLK_I,
  input  wire logic                 RST_I,
  input  wire tacf_pkg::tacf_cfg_t  CFG_I,
  input  wire logic                 CMD_REQA_I,
  input  wire logic                 CMD_WUPA_I,
  input  wire logic                 CMD_TX_CRC_I,
  input  wire logic                 FIFO_POP_O,
  input  wire logic                 TX_EN_O,
  input  wire logic                 RX_VALID_O,
  input  wire tacf_pkg::tacf_stat_t STAT_O
);
  int   pops;
  int   since;
  int   eff;
  logic bad_len;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  assign bad_len = CFG_I.frame_mode &&
    (CFG_I.tx_count == 9'h000 || CFG_I.tx_count > 9'h0fe);
  // Without the tolerant bit only the coarse grid applies
  assign eff = int'(CFG_I.antcl ? CFG_I.mask_time
                                : CFG_I.mask_time & 8'hfe);
  always_ff @(posedge CLK_I) begin
    if (RST_I || (CMD_TX_CRC_I && !STAT_O.busy)) pops <= 0;
    else if (FIFO_POP_O) pops <= pops + 1;
    // Saturates so a long idle cannot wrap
    if (RST_I || STAT_O.eot) since <= 0;
    else if (since < 65535) since <= since + 1;
  end
  sequence s_short;
    (CMD_REQA_I || CMD_WUPA_I) && !STAT_O.busy;
  endsequence
  sequence s_refuse;
    CMD_TX_CRC_I && !STAT_O.busy && bad_len;
  endsequence
  sequence s_to_eot;
    ##[0:1000] STAT_O.eot;
  endsequence
  AST_SHORT_FRAME:
    assert property (s_short |=> STAT_O.busy ##0
      (!FIFO_POP_O throughout s_to_eot)) else $error("short frame hung");
  AST_LEN_FLAG:
    assert property (s_refuse |-> ##[1:2] STAT_O.len_err)
    else $error("bad length not flagged");
  AST_LEN_SILENT:
    assert property (s_refuse |=> (!TX_EN_O && !FIFO_POP_O) [*8])
    else $error("bad length still sent");
  AST_TAKE:
    assert property (CMD_TX_CRC_I && !STAT_O.busy && CFG_I.frame_mode &&
      !bad_len |=> STAT_O.busy) else $error("frame command not taken");
  AST_POP_COUNT:
    assert property (STAT_O.eot && CFG_I.frame_mode |->
      pops == int'(CFG_I.tx_count)) else $error("payload count wrong");
  AST_POP_IN_TX:
    assert property (FIFO_POP_O |-> TX_EN_O) else $error("pop while idle");
  AST_MASK_WINDOW:
    assert property ($rose(STAT_O.rx_on) |-> since * 100 >= eff * 4720 -
      3000 && since * 100 <= eff * 4720 + 3000) else $error("mask time off");
  AST_RX_GATED:
    assert property (RX_VALID_O |-> $past(STAT_O.rx_on) ||
      $past(STAT_O.rx_on, 2)) else $error("byte taken while masked");
  AST_TX_OFF:
    assert property (STAT_O.rx_on |-> !TX_EN_O) else $error("tx during rx");
  AST_NO_COLL_FERR:
    assert property (STAT_O.frame_err |-> !CFG_I.antcl)
    else $error("framing error in tolerant mode");
endmodule
bind tacf_framer tacf_framer_chk chk_u (.CLK_I(CLK_I), .RST_I(RST_I),
  .CFG_I(CFG_I), .CMD_REQA_I(CMD_REQA_I), .CMD_WUPA_I(CMD_WUPA_I),
  .CMD_TX_CRC_I(CMD_TX_CRC_I), .FIFO_POP_O(FIFO_POP_O), .TX_EN_O(TX_EN_O),
  .RX_VALID_O(RX_VALID_O), .STAT_O(STAT_O));
`default_nettype wire

// file: dv/tacf_tag_model.sv
`timescale 1ns/100ps
`default_nettype none
module tacf_tag_model (
  input  wire logic        clk_i,
  input  wire logic        listen_i,
  input  wire logic        arm_i,
  input  wire logic [15:0] reply_i,
  input  wire logic [4:0]  nbits_i,
  input  wire logic [4:0]  coll_i,
  input  wire logic [3:0]  gap_i,
  output logic             stb_o,
  output logic             bit_o,
  output logic             coll_o,
  output logic             end_o
);
  // Between strobes the data line toggles so stale values never match
  task automatic put(input logic b, input logic c);
    @(posedge clk_i);
    #5;
    stb_o = 1'b1;
    bit_o = b;
    coll_o = c;
    @(posedge clk_i);
    #5;
    stb_o = 1'b0;
    coll_o = 1'b0;
    repeat (gap_i) begin
      bit_o = ~bit_o;
      @(posedge clk_i);
      #5;
    end
  endtask
  initial begin
    {stb_o, bit_o, coll_o, end_o} = 4'h0;
    forever begin
      @(posedge clk_i iff (arm_i && listen_i));
      for (int i = 0; i < nbits_i; i++) begin
        put(reply_i[i], coll_i == 5'(i));
        if (i % 8 == 7) put(~^reply_i[i -: 8], 1'b0);
      end
      @(posedge clk_i);
      #5;
      end_o = 1'b1;
      @(posedge clk_i);
      #5;
      end_o = 1'b0;
      @(posedge clk_i iff !listen_i);
    end
  end
endmodule
`default_nettype wire

// file: dv/typea_anticollision_framer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module typea_anticollision_framer_tb;
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  tacf_pkg::tacf_cfg_t  cfg = '0;
  logic [3:0]           cmd = 4'h0;
  logic [7:0]           fifo_data = 8'h00;
  logic                 fifo_valid = 1'b0;
  logic                 fifo_pop, pop_q, tx_bit, tx_en, rx_valid;
  logic                 stb, rbit, rcoll, rend, cur, arm = 1'b0;
  logic [7:0]           rx_data;
  tacf_pkg::tacf_stat_t stat;
  logic [4:0]           coll_at = 5'h1f;
  logic [3:0]           gap = 4'h2;
  logic [4:0]           seen;
  logic [7:0]           fq[$];
  logic [7:0]           rq[$];
  logic                 bq[$];
  int                   run, div, cyc, bad_count, checks_done;
  always #50 clk = ~clk;
  tacf_framer dut_u (.CLK_I(clk), .RST_I(rst), .CFG_I(cfg),
    .CMD_REQA_I(cmd[2]), .CMD_WUPA_I(cmd[1]), .CMD_TX_CRC_I(cmd[0]),
    .CMD_TX_RAW_I(cmd[3]), .FIFO_DATA_I(fifo_data), .FIFO_VALID_I(fifo_valid),
    .FIFO_POP_O(fifo_pop), .TX_BIT_O(tx_bit), .TX_EN_O(tx_en),
    .RX_STB_I(stb), .RX_BIT_I(rbit), .RX_COLL_I(rcoll), .RX_END_I(rend),
    .RX_DATA_O(rx_data), .RX_VALID_O(rx_valid), .STAT_O(stat));
  tacf_tag_model tag_u (.clk_i(clk), .listen_i(stat.rx_on), .arm_i(arm),
    .reply_i(16'h0344), .nbits_i(5'h10), .coll_i(coll_at), .gap_i(gap),
    .stb_o(stb), .bit_o(rbit), .coll_o(rcoll), .end_o(rend));
  // ---------------------------------------------------------------
  // Capture
  // ---------------------------------------------------------------
  // Run lengths are turned back into bits, since ticks are not visible
  task automatic flush();
    repeat ((run * 1356 + 16000 * div) / (32000 * div)) bq.push_back(cur);
    run = 0;
  endtask
  always @(negedge clk) begin
    pop_q = fifo_pop;
    seen |= {stat.eot, stat.coll, stat.frame_err, stat.len_err, tx_en};
    if (rx_valid === 1'b1) rq.push_back(rx_data);
    if (tx_en === 1'b1) begin
      if (run > 0 && tx_bit !== cur) flush();
      cur = tx_bit;
      run++;
    end else if (run > 0) flush();
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      bad_count++;
      end_sim();
    end
    #5;
    if (pop_q === 1'b1 && fq.size() > 0) void'(fq.pop_front());
    fifo_valid = fq.size() > 0;
    fifo_data = fifo_valid ? fq[0] : ~fifo_data;
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic fire(input logic [3:0] c);
    seen = 5'h00;
    bq.delete();
    rq.delete();
    @(posedge clk);
    #5;
    cmd = c;
    @(posedge clk);
    #5;
    cmd = 4'h0;
  endtask
  task automatic wait_idle();
    int n = 0;
    while (stat.busy !== 1'b0 && n < 30000) begin
      @(posedge clk);
      #5;
      n++;
    end
  endtask
  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0]  d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = {r[14:0], 1'b0} ^ (r[15] ? 16'h1021 : 16'h0000);
    end
    return r;
  endfunction
  function automatic logic [7:0] get_byte(input int s);
    logic [7:0] b;
    for (int i = 0; i < 8; i++) b[7 - i] = bq[s + i];
    return b;
  endfunction
  // Type A bits go out LSB first, parity in the ninth slot
  function automatic logic [15:0] get_bits(input int s, input int n);
    logic [15:0] v;
    v = 16'h0000;
    for (int i = 0; i < n; i++) v[i] = bq[s + i];
    return v;
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0]  exp [7];
    logic [15:0] crc;
    int          z;
    div = 4;
    repeat (3) @(posedge clk);
    #5;
    rst = 1'b0;
    #2000;
    for (int k = 0; k < 2; k++) begin
      cfg = '0;
      cfg.antcl = 1'b1;
      cfg.no_crc_rx = 1'b1;
      cfg.mask_time = 8'h05;
      cfg.nrt_time = 16'h0100;
      coll_at = k ? 5'h08 : 5'h0b;
      gap = k ? 4'h7 : 4'h2;
      arm = 1'b1;
      fire(k ? 4'h2 : 4'h4);
      wait_idle();
      arm = 1'b0;
      check_val(16'(seen), 16'h0019);
      check_val(16'(rq[0]), 16'h0044);
      check_val(16'(rq.size()), 16'h0002);
      check_val({5'h00, stat.coll_byte, stat.coll_bit},
                k ? 16'h0008 : 16'h000b);
      $display("collision case %0d done", k);
    end
    cfg = '0;
    cfg.antcl = 1'b1;
    cfg.no_crc_rx = 1'b1;
    cfg.mask_time = 8'h05;
    cfg.nrt_time = 16'h0010;
    cfg.tx_count = 9'h002;
    fq = '{8'h93, 8'h20};
    fire(4'h8);
    wait_idle();
    z = 0;
    while (z < bq.size() && bq[z] !== 1'b1) z++;
    check_val(16'(z <= 1), 16'h0001);
    check_val(get_bits(z, 9), 16'h0193);
    check_val(get_bits(z + 9, 9), 16'h0020);
    $display("anticollision frame done");
    for (int k = 0; k < 2; k++) begin
      cfg = '0;
      cfg.frame_mode = 1'b1;
      cfg.tx_count = k ? 9'h0ff : 9'h000;
      fire(4'h1);
      repeat (4) @(posedge clk);
      #5;
      check_val(16'(seen), 16'h0002);
      $display("length refusal %0d done", k);
    end
    for (int p = 0; p < 4; p++) begin
      cfg = '0;
      cfg.frame_mode = 1'b1;
      cfg.rate_424 = p[0];
      {cfg.preamble_length_hi, cfg.preamble_length_lo} = 2'(p);
      cfg.tx_count = 9'h002;
      cfg.nrt_time = 16'h0010;
      cfg.mask_time = 8'h02;
      div = p[0] ? 1 : 2;
      fq = '{8'h5a, 8'hc3};
      exp = '{8'hb2, 8'h4d, 8'h03, 8'h5a, 8'hc3, 8'h00, 8'h00};
      crc = 16'h0000;
      for (int k = 2; k < 5; k++) crc = crc_step(crc, exp[k]);
      exp[5] = crc[15:8];
      exp[6] = crc[7:0];
      fire(4'h1);
      wait_idle();
      z = 0;
      while (z < bq.size() && bq[z] !== 1'b1) z++;
      check_val(16'(z >= 48 + 16 * p && z <= 49 + 16 * p), 16'h1);
      for (int k = 0; k < 7; k++) begin
        check_val({8'h00, get_byte(z + 8 * k)}, {8'h00, exp[k]});
      end
      $display("frame preamble code %0d done", p);
    end
    end_sim();
  end
endmodule
`default_nettype wire
